// *** core/gpib_device_consts.vh ***
// Constants for the instrument bus device interface
`ifndef GPIB_DEVICE_CONSTS_VH
`define GPIB_DEVICE_CONSTS_VH
`define CLK_MHZ 100
`define SETTLE_NS 2000
`define BLINK_MS 250
`define MODE_OFF 2'h0
`define MODE_TALK 2'h1
`define MODE_LISTEN 2'h2
`define MODE_TL 2'h3
`define ADDR_MAX 5'h1E
`define CMD_GTL 8'h01
`define CMD_SDC 8'h04
`define CMD_GET 8'h08
`define CMD_LLO 8'h11
`define CMD_DCL 8'h14
`define CMD_SPE 8'h18
`define CMD_SPD 8'h19
`define CMD_UNL 8'h3F
`define CMD_UNT 8'h5F
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define CHAR_LF 8'h0A
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RXDATA 8'h08
`define REG_TXDATA 8'h0C
`define REG_SRQ 8'h10
`define REG_EVENT 8'h14
`define RST_MODE 2'h3
`define RST_TERM 1'h1
`define RST_ADDR 5'h00
`endif

// *** core/gpib_device.v ***
// Device-side instrument bus interface with panel and Wishbone registers
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "gpib_device_consts.vh"
module gpib_device #(
   parameter BLINK_CYC = `BLINK_MS * 1000 * `CLK_MHZ
)(
   input wire core_clk_i,
   input wire reset_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [7:0] dio_i,
   output reg [7:0] dio_o,
   output wire dio_oe_o,
   input wire dav_i,
   output wire dav_o,
   output wire dav_oe_o,
   input wire nrfd_i,
   output wire nrfd_o,
   output wire nrfd_oe_o,
   input wire ndac_i,
   output wire ndac_o,
   output wire ndac_oe_o,
   input wire eoi_i,
   output reg eoi_o,
   output wire eoi_oe_o,
   output wire srq_o,
   output wire srq_oe_o,
   input wire atn_i,
   input wire ifc_i,
   input wire ren_i,
   input wire key_menu_i,
   input wire key_mode_i,
   input wire key_term_i,
   input wire key_addr_i,
   input wire panel_op_i,
   input wire panel_exempt_i,
   output wire panel_exec_o,
   output wire analog_var_o,
   output reg [5:0] keypad_lamp_o,
   output wire menu_lamp_o,
   output wire addr_lamp_o,
   output wire srq_lamp_o,
   output wire rwls_lamp_o,
   output reg trigger_o,
   output reg dev_clear_o
);
   localparam SETTLE_CYC = (`SETTLE_NS * `CLK_MHZ + 999) / 1000;
   localparam [7:0] SETTLE_LAST = SETTLE_CYC[7:0] - 8'h01;
   localparam [31:0] BLINK_LAST = BLINK_CYC - 1;
   localparam [1:0] RL_LOCS = 2'h0;
   localparam [1:0] RL_REMS = 2'h1;
   localparam [1:0] RL_LWLS = 2'h2;
   localparam [1:0] RL_RWLS = 2'h3;
   localparam [1:0] SEL_NONE = 2'h0;
   localparam [1:0] SEL_MODE = 2'h1;
   localparam [1:0] SEL_TERM = 2'h2;
   localparam [1:0] SEL_ADDR = 2'h3;
   localparam AH_IDLE = 1'b0;
   localparam AH_ACPT = 1'b1;
   localparam [1:0] SH_IDLE = 2'h0;
   localparam [1:0] SH_SETTLE = 2'h1;
   localparam [1:0] SH_DAV = 2'h2;

   // -----------------------------------------------------------------
   // Settings and front-panel menu
   // -----------------------------------------------------------------
   reg [1:0] mode_reg;
   reg term_reg;
   reg [4:0] addr_reg;
   reg [1:0] pend_mode_reg;
   reg pend_term_reg;
   reg [4:0] pend_addr_reg;
   reg menu_reg;
   reg [1:0] sel_reg;
   reg [1:0] rl_reg;
   reg [31:0] blink_cnt_reg;
   reg blink_reg;
   wire rwls = (rl_reg == RL_RWLS);

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= 1'b0;
      end
      else if (blink_cnt_reg == BLINK_LAST)
      begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= ~blink_reg;
      end
      else
         blink_cnt_reg <= blink_cnt_reg + 32'h1;
   end

   // Menu viewing stays live in lockout; only applying is refused there
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mode_reg <= `RST_MODE;
         term_reg <= `RST_TERM;
         addr_reg <= `RST_ADDR;
         pend_mode_reg <= `RST_MODE;
         pend_term_reg <= `RST_TERM;
         pend_addr_reg <= `RST_ADDR;
         menu_reg <= 1'b0;
         sel_reg <= SEL_NONE;
      end
      else if (key_menu_i)
      begin
         if (!menu_reg)
         begin
            menu_reg <= 1'b1;
            sel_reg <= SEL_NONE;
            pend_mode_reg <= mode_reg;
            pend_term_reg <= term_reg;
            pend_addr_reg <= addr_reg;
         end
         else
         begin
            menu_reg <= 1'b0;
            sel_reg <= SEL_NONE;
            if (!rwls)
            begin
               mode_reg <= pend_mode_reg;
               term_reg <= pend_term_reg;
               addr_reg <= pend_addr_reg;
            end
         end
      end
      else if (menu_reg)
      begin
         if (key_mode_i)
         begin
            sel_reg <= SEL_MODE;
            if (sel_reg == SEL_MODE)
               pend_mode_reg <= pend_mode_reg + 2'h1;
         end
         else if (key_term_i)
         begin
            sel_reg <= SEL_TERM;
            if (sel_reg == SEL_TERM)
               pend_term_reg <= ~pend_term_reg;
         end
         else if (key_addr_i)
         begin
            sel_reg <= SEL_ADDR;
            if (sel_reg == SEL_ADDR)
            begin
               if (pend_addr_reg >= `ADDR_MAX)
                  pend_addr_reg <= 5'h00;
               else
                  pend_addr_reg <= pend_addr_reg + 5'h01;
            end
         end
      end
   end

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         keypad_lamp_o <= 6'h00;
      else if (!menu_reg)
         keypad_lamp_o <= 6'h00;
      else
         case (sel_reg)
            SEL_MODE:
               keypad_lamp_o <= {2'b00, blink_reg, 1'b0,
                  pend_mode_reg[1], pend_mode_reg[0]};
            SEL_TERM:
               keypad_lamp_o <= {1'b0, blink_reg, 1'b0,
                  pend_term_reg, 2'b00};
            SEL_ADDR:
               keypad_lamp_o <= {blink_reg, pend_addr_reg};
            default:
               keypad_lamp_o <= 6'h00;
         endcase
   end
   assign menu_lamp_o = menu_reg;

   // -----------------------------------------------------------------
   // Addressing, remote-local and command decode
   // -----------------------------------------------------------------
   reg ta_reg;
   reg la_reg;
   reg spms_reg;
   reg ah_reg;
   reg cmd_stb_reg;
   reg [7:0] cmd_reg;
   reg [1:0] sh_reg;
   reg rx_full_reg;
   reg tx_full_reg;
   reg rsv_reg;
   reg pon_reg;
   reg var_cal_reg;

   wire bus_on = (mode_reg != `MODE_OFF);
   wire talk_only = (mode_reg == `MODE_TALK);
   wire listen_only = (mode_reg == `MODE_LISTEN);
   wire talker = bus_on & (talk_only | ta_reg);
   wire listener = bus_on & (listen_only | la_reg);
   wire tacs = talker & ~atn_i;
   wire lacs = listener & ~atn_i;
   wire own_talk = cmd_stb_reg & (cmd_reg[6:5] == `GRP_TALK)
      & (cmd_reg[4:0] == addr_reg);
   wire own_listen = cmd_stb_reg & (cmd_reg[6:5] == `GRP_LISTEN)
      & (cmd_reg[4:0] == addr_reg);
   wire other_talk = cmd_stb_reg & (cmd_reg[6:5] == `GRP_TALK)
      & (cmd_reg[4:0] != addr_reg);
   wire dev_clear = cmd_stb_reg & ((cmd_reg == `CMD_DCL)
      | ((cmd_reg == `CMD_SDC) & listener));
   wire trig_cmd = cmd_stb_reg & (cmd_reg == `CMD_GET) & listener;
   wire gtl_cmd = cmd_stb_reg & (cmd_reg == `CMD_GTL) & listener;
   wire llo_cmd = cmd_stb_reg & (cmd_reg == `CMD_LLO);
   wire rtl = panel_op_i & ~panel_exempt_i;

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ta_reg <= 1'b0;
         la_reg <= 1'b0;
         spms_reg <= 1'b0;
      end
      else if (ifc_i || !bus_on)
      begin
         ta_reg <= 1'b0;
         la_reg <= 1'b0;
         spms_reg <= 1'b0;
      end
      else if (cmd_stb_reg)
      begin
         if (own_talk)
            ta_reg <= 1'b1;
         else if (other_talk || cmd_reg == `CMD_UNT)
            ta_reg <= 1'b0;
         if (own_listen)
            la_reg <= 1'b1;
         else if (cmd_reg == `CMD_UNL)
            la_reg <= 1'b0;
         if (cmd_reg == `CMD_SPE)
            spms_reg <= 1'b1;
         else if (cmd_reg == `CMD_SPD)
            spms_reg <= 1'b0;
      end
   end

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rl_reg <= RL_LOCS;
      else if (!ren_i || !bus_on)
         rl_reg <= RL_LOCS;
      else
         case (rl_reg)
            RL_LOCS:
               if (llo_cmd)
                  rl_reg <= RL_LWLS;
               else if (own_listen)
                  rl_reg <= RL_REMS;
            RL_REMS:
               if (llo_cmd)
                  rl_reg <= RL_RWLS;
               else if (gtl_cmd || rtl)
                  rl_reg <= RL_LOCS;
            RL_LWLS:
               if (own_listen)
                  rl_reg <= RL_RWLS;
            default:
               if (gtl_cmd)
                  rl_reg <= RL_LWLS;
         endcase
   end

   // Remote state leaves on rtl, so a panel op there still runs
   assign panel_exec_o = panel_op_i
      & (~rwls | panel_exempt_i);
   assign analog_var_o = ~var_cal_reg;
   assign rwls_lamp_o = rwls;
   assign addr_lamp_o = talker | listener;
   assign srq_lamp_o = rsv_reg;

   // -----------------------------------------------------------------
   // Acceptor handshake
   // -----------------------------------------------------------------
   reg [7:0] rx_byte_reg;
   reg rx_eoi_reg;
   wire acc_on = bus_on & (atn_i | lacs);
   wire acc_ready = atn_i | ~rx_full_reg;

   // Data is taken in any remote state; commands never wait on buffers
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ah_reg <= AH_IDLE;
         cmd_stb_reg <= 1'b0;
         cmd_reg <= 8'h00;
      end
      else
      begin
         cmd_stb_reg <= 1'b0;
         case (ah_reg)
            AH_IDLE:
               if (acc_on && acc_ready && dav_i)
               begin
                  ah_reg <= AH_ACPT;
                  if (atn_i)
                  begin
                     cmd_stb_reg <= 1'b1;
                     cmd_reg <= {1'b0, dio_i[6:0]};
                  end
               end
            default:
               if (!dav_i || !acc_on)
                  ah_reg <= AH_IDLE;
         endcase
      end
   end
   assign nrfd_o = 1'b1;
   assign ndac_o = 1'b1;
   assign nrfd_oe_o = acc_on & ((ah_reg == AH_ACPT) | ~acc_ready);
   assign ndac_oe_o = acc_on & (ah_reg == AH_IDLE);

   // -----------------------------------------------------------------
   // Source handshake
   // -----------------------------------------------------------------
   reg [7:0] settle_reg;
   reg [7:0] tx_byte_reg;
   reg tx_eoi_reg;
   reg [5:0] reason_reg;
   wire [7:0] status_byte = {1'b0, rsv_reg, reason_reg};
   wire src_has = spms_reg | tx_full_reg;
   wire sh_done = (sh_reg == SH_DAV) & ~ndac_i & tacs;

   // Leaving active talk drops the byte but keeps it queued to resend
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sh_reg <= SH_IDLE;
         settle_reg <= 8'h00;
         dio_o <= 8'h00;
         eoi_o <= 1'b0;
      end
      else if (!tacs || dev_clear)
         sh_reg <= SH_IDLE;
      else
         case (sh_reg)
            SH_IDLE:
               if (src_has)
               begin
                  sh_reg <= SH_SETTLE;
                  settle_reg <= 8'h00;
                  dio_o <= spms_reg ? status_byte : tx_byte_reg;
                  eoi_o <= ~spms_reg & tx_eoi_reg;
               end
            SH_SETTLE:
               if (settle_reg != SETTLE_LAST)
                  settle_reg <= settle_reg + 8'h01;
               else if (!nrfd_i)
                  sh_reg <= SH_DAV;
            SH_DAV:
               if (!ndac_i)
                  sh_reg <= SH_IDLE;
            default:
               sh_reg <= SH_IDLE;
         endcase
   end
   assign dio_oe_o = tacs & (sh_reg != SH_IDLE);
   assign eoi_oe_o = dio_oe_o;
   assign dav_o = 1'b1;
   assign dav_oe_o = tacs & (sh_reg == SH_DAV);
   assign srq_o = 1'b1;
   assign srq_oe_o = bus_on & rsv_reg;

   // -----------------------------------------------------------------
   // Wishbone slave and buffers
   // -----------------------------------------------------------------
   reg ev_trig_reg;
   reg ev_ifc_reg;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land on the edge that sees ack, where the master commits them
   wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   wire wr0 = wb_wr & wb_sel_i[0];
   wire wr1 = wb_wr & wb_sel_i[1];
   wire rd = wb_req & ~wb_we_i;
   wire rx_take = acc_on & ~atn_i & acc_ready & dav_i
      & (ah_reg == AH_IDLE);
   wire rx_end = rx_eoi_reg | (term_reg & (rx_byte_reg == `CHAR_LF));
   reg [31:0] rd_data;

   always @*
   begin
      rd_data = 32'h0;
      if (wb_adr_i == `REG_CTRL)
         rd_data = {31'h0, var_cal_reg};
      else if (wb_adr_i == `REG_STATUS)
         rd_data = {16'h0, addr_reg, term_reg, mode_reg, pon_reg,
            rsv_reg, tx_full_reg, rx_full_reg, rwls, listener,
            talker, talker | listener};
      else if (wb_adr_i == `REG_RXDATA)
         rd_data = {22'h0, rx_end, rx_eoi_reg, rx_byte_reg};
      else if (wb_adr_i == `REG_SRQ)
         rd_data = {24'h0, status_byte};
      else if (wb_adr_i == `REG_EVENT)
         rd_data = {30'h0, ev_ifc_reg, ev_trig_reg};
   end

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (rd)
            wb_dat_o <= rd_data;
      end
   end

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rx_full_reg <= 1'b0;
         rx_byte_reg <= 8'h00;
         rx_eoi_reg <= 1'b0;
         tx_full_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
         tx_eoi_reg <= 1'b0;
         var_cal_reg <= 1'b0;
      end
      else
      begin
         if (wr0 && wb_adr_i == `REG_CTRL)
            var_cal_reg <= wb_dat_i[0];
         if (dev_clear)
            rx_full_reg <= 1'b0;
         else if (rx_take)
         begin
            rx_full_reg <= 1'b1;
            rx_byte_reg <= dio_i;
            rx_eoi_reg <= eoi_i;
         end
         else if (rd && wb_adr_i == `REG_RXDATA)
            rx_full_reg <= 1'b0;
         if (dev_clear)
            tx_full_reg <= 1'b0;
         else if (sh_done && !spms_reg)
            tx_full_reg <= 1'b0;
         else if (wr0 && wb_adr_i == `REG_TXDATA && !tx_full_reg)
         begin
            tx_full_reg <= 1'b1;
            tx_byte_reg <= wb_dat_i[7:0];
            tx_eoi_reg <= wr1 & wb_dat_i[8];
         end
      end
   end

   // -----------------------------------------------------------------
   // Service request, events and pulses
   // -----------------------------------------------------------------
   wire srq_wr = wr0 & (wb_adr_i == `REG_SRQ);
   wire ev_wr = wr0 & (wb_adr_i == `REG_EVENT);

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rsv_reg <= 1'b0;
         reason_reg <= 6'h00;
         pon_reg <= 1'b1;
         ev_trig_reg <= 1'b0;
         ev_ifc_reg <= 1'b0;
         trigger_o <= 1'b0;
         dev_clear_o <= 1'b0;
      end
      else
      begin
         trigger_o <= trig_cmd;
         dev_clear_o <= dev_clear;
         if (srq_wr && wb_dat_i[6])
         begin
            rsv_reg <= 1'b1;
            reason_reg <= wb_dat_i[5:0];
         end
         else if (sh_done && spms_reg)
            rsv_reg <= 1'b0;
         else if (dev_clear && !pon_reg)
         begin
            rsv_reg <= 1'b0;
            reason_reg <= 6'h00;
         end
         if (srq_wr && wb_dat_i[7])
            pon_reg <= 1'b0;
         if (trig_cmd)
            ev_trig_reg <= 1'b1;
         else if (dev_clear || (ev_wr && wb_dat_i[0]))
            ev_trig_reg <= 1'b0;
         if (ifc_i)
            ev_ifc_reg <= 1'b1;
         else if (dev_clear || (ev_wr && wb_dat_i[1]))
            ev_ifc_reg <= 1'b0;
      end
   end
endmodule // gpib_device

// *** bench/gpib_device_checker.sv ***
// Port-level assertions for the instrument bus device
`timescale 1ns/100ps
module gpib_device_checker (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire dav_i,
   input wire nrfd_i,
   input wire atn_i,
   input wire ifc_i,
   input wire ren_i,
   input wire dio_oe_o,
   input wire eoi_oe_o,
   input wire dav_oe_o,
   input wire nrfd_oe_o,
   input wire ndac_oe_o,
   input wire panel_op_i,
   input wire panel_exempt_i,
   input wire panel_exec_o,
   input wire addr_lamp_o,
   input wire rwls_lamp_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // ----------
   // Acceptor steps and port assertions
   // ----------
   sequence s_taken;
      $rose(dav_i) && atn_i && !nrfd_oe_o;
   endsequence
   sequence s_held;
      nrfd_oe_o && !ndac_oe_o;
   endsequence
   a_ack_pulse: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a single pulse");
   a_cmd_taken: assert property (s_taken |=> s_held)
      else $error("command byte not taken");
   a_cmd_done: assert property (
      s_held ##0 $fell(dav_i) |=> ndac_oe_o)
      else $error("accept not ended");
   a_dav_ready: assert property (
      $rose(dav_oe_o) |-> !$past(nrfd_i) && dio_oe_o)
      else $error("data valid before ready");
   // Data must sit on the lines well before it is marked valid
   a_data_settled: assert property (
      $rose(dav_oe_o) |-> $past(dio_oe_o, 8))
      else $error("data valid too early");
   a_eoi_tracks: assert property (eoi_oe_o == dio_oe_o)
      else $error("end line drive mismatch");
   a_lockout_panel: assert property (
      rwls_lamp_o && panel_op_i && !panel_exempt_i |-> !panel_exec_o)
      else $error("panel acted in lockout");
   a_local_panel: assert property (
      !rwls_lamp_o && panel_op_i |-> panel_exec_o)
      else $error("panel ignored in local");
   a_ifc_unaddr: assert property (ifc_i [*3] |-> !addr_lamp_o)
      else $error("still addressed after clear");
   a_ren_local: assert property (!ren_i [*3] |-> !rwls_lamp_o)
      else $error("lockout lamp without remote enable");
endmodule // gpib_device_checker
bind gpib_device gpib_device_checker u_chk (
   .core_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dav_i,
   .nrfd_i, .atn_i, .ifc_i, .ren_i, .dio_oe_o, .eoi_oe_o, .dav_oe_o,
   .nrfd_oe_o, .ndac_oe_o, .panel_op_i, .panel_exempt_i, .panel_exec_o,
   .addr_lamp_o, .rwls_lamp_o);

// *** bench/gpib_ctrl_model.sv ***
// Behavioural bus controller facing the device
`timescale 1ns/100ps
module gpib_ctrl_model (
   input wire clk_i,
   input wire [7:0] dio_i,
   input wire eoi_i,
   input wire dav_oe_i,
   input wire nrfd_oe_i,
   input wire ndac_oe_i,
   output reg [7:0] c_dio_o,
   output reg c_dav_o,
   output reg c_nrfd_o,
   output reg c_ndac_o,
   output reg atn_o,
   output reg ifc_o,
   output reg ren_o
);
   wire [2:0] st = {dav_oe_i, ndac_oe_i, nrfd_oe_i};
   integer n_to = 0;
   // Idle holds not-ready so a pending talker cannot finish unheard
   initial
   begin
      c_dio_o = 8'h00;
      c_dav_o = 1'h0;
      c_nrfd_o = 1'h1;
      c_ndac_o = 1'h1;
      atn_o = 1'h0;
      ifc_o = 1'h0;
      ren_o = 1'h0;
   end
   task wt(input integer b, input v);
      integer n;
      begin
         n = 0;
         while (st[b] !== v && n < 400)
         begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n == 400)
            n_to = n_to + 1;
      end
   endtask
   task ctl(input a, input i, input r);
      begin
         atn_o <= a;
         ifc_o <= i;
         ren_o <= r;
         @(posedge clk_i);
      end
   endtask
   task send(input a, input [7:0] b);
      begin
         c_nrfd_o <= 1'h0;
         c_ndac_o <= 1'h0;
         atn_o <= a;
         c_dio_o <= b;
         @(posedge clk_i);
         wt(0, 1'h0);
         c_dav_o <= 1'h1;
         @(posedge clk_i);
         wt(1, 1'h0);
         c_dav_o <= 1'h0;
         c_dio_o <= 8'h00;
         @(posedge clk_i);
         wt(1, 1'h1);
         c_nrfd_o <= 1'h1;
         c_ndac_o <= 1'h1;
         @(posedge clk_i);
      end
   endtask
   task recv(input integer d, output [7:0] b, output e);
      begin
         repeat (d) @(posedge clk_i);
         c_nrfd_o <= 1'h0;
         @(posedge clk_i);
         wt(2, 1'h1);
         b = dio_i;
         e = eoi_i;
         c_nrfd_o <= 1'h1;
         repeat (d) @(posedge clk_i);
         c_ndac_o <= 1'h0;
         @(posedge clk_i);
         wt(2, 1'h0);
         c_ndac_o <= 1'h1;
         @(posedge clk_i);
      end
   endtask
endmodule // gpib_ctrl_model

// *** bench/tb_top.sv ***
// Self-checking bench for the instrument bus device
`timescale 1ns/100ps
module tb_top;
   reg core_clk_i = 1'h0;
   reg reset_n_i = 1'h0;
   reg wb_cyc_i = 1'h0;
   reg wb_stb_i = 1'h0;
   reg wb_we_i = 1'h0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [3:0] wb_sel_i = 4'hF;
   reg [31:0] wb_dat_i = 32'h0;
   reg [3:0] key = 4'h0;
   reg panel_op_i = 1'h0;
   reg panel_exempt_i = 1'h0;
   reg [31:0] q;
   reg [7:0] rb;
   reg re;
   integer n_fail = 0;
   integer cmp_count = 0;
   integer i;
   integer n_trg = 0;
   integer n_dcl = 0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, dio_oe_o, dav_oe_o, nrfd_oe_o, ndac_oe_o, eoi_o, eoi_oe_o;
   wire dav_o, nrfd_o, ndac_o, srq_o, srq_oe_o, panel_exec_o, analog_var_o;
   wire menu_lamp_o, addr_lamp_o, srq_lamp_o, rwls_lamp_o, trigger_o;
   wire dev_clear_o, c_dav, c_nrfd, c_ndac, atn_i, ifc_i, ren_i;
   wire [7:0] dio_o, c_dio;
   wire [5:0] keypad_lamp_o;
   wire key_menu_i = key[0];
   wire key_mode_i = key[1];
   wire key_term_i = key[2];
   wire key_addr_i = key[3];
   // Bus lines are wired-OR in asserted-high logic
   wire [7:0] dio_i = c_dio | (dio_oe_o ? dio_o : 8'h00);
   wire dav_i = c_dav | (dav_oe_o & dav_o);
   wire nrfd_i = c_nrfd | (nrfd_oe_o & nrfd_o);
   wire ndac_i = c_ndac | (ndac_oe_o & ndac_o);
   wire eoi_i = eoi_oe_o & eoi_o;
   always #5 core_clk_i = ~core_clk_i;
   // Pulse outputs are counted so each command's effect can be checked
   always @(posedge core_clk_i)
   begin
      if (trigger_o === 1'h1)
         n_trg <= n_trg + 1;
      if (dev_clear_o === 1'h1)
         n_dcl <= n_dcl + 1;
   end
   gpib_device #(.BLINK_CYC(4)) dut (
      .core_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dio_i, .dio_o, .dio_oe_o,
      .dav_i, .dav_o, .dav_oe_o, .nrfd_i, .nrfd_o, .nrfd_oe_o, .ndac_i,
      .ndac_o, .ndac_oe_o, .eoi_i, .eoi_o, .eoi_oe_o, .srq_o, .srq_oe_o,
      .atn_i, .ifc_i, .ren_i, .key_menu_i, .key_mode_i, .key_term_i,
      .key_addr_i, .panel_op_i, .panel_exempt_i, .panel_exec_o,
      .analog_var_o, .keypad_lamp_o, .menu_lamp_o, .addr_lamp_o,
      .srq_lamp_o, .rwls_lamp_o, .trigger_o, .dev_clear_o);
   gpib_ctrl_model u_ctl (.clk_i(core_clk_i), .dio_i(dio_i), .eoi_i(eoi_i),
      .dav_oe_i(dav_oe_o), .nrfd_oe_i(nrfd_oe_o), .ndac_oe_i(ndac_oe_o),
      .c_dio_o(c_dio), .c_dav_o(c_dav), .c_nrfd_o(c_nrfd), .c_ndac_o(c_ndac),
      .atn_o(atn_i), .ifc_o(ifc_i), .ren_o(ren_i));
   // ----------
   // Tasks
   // ----------
   task conclude;
      begin
         $display("fails %0d compares %0d", n_fail, cmp_count);
         if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e)
         begin
            n_fail = n_fail + 1;
            $display("ERROR %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'h1;
         wb_stb_i <= 1'h1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         @(posedge core_clk_i);
         while (wb_ack_o !== 1'h1)
         begin
            n = n + 1;
            if (n > 20)
            begin
               n_fail = n_fail + 1;
               conclude;
            end
            @(posedge core_clk_i);
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'h0;
         wb_stb_i <= 1'h0;
         wb_we_i <= 1'h0;
         @(posedge core_clk_i);
      end
   endtask
   task press(input [3:0] k);
      begin
         key <= k;
         @(posedge core_clk_i);
         key <= 4'h0;
         repeat (3) @(posedge core_clk_i);
      end
   endtask
   task panel(input x, input e);
      begin
         panel_exempt_i <= x;
         panel_op_i <= 1'h1;
         @(posedge core_clk_i);
         chk(panel_exec_o, e);
         panel_op_i <= 1'h0;
         @(posedge core_clk_i);
      end
   endtask
   task blink(input integer b);
      integer c;
      reg p;
      begin
         c = 0;
         p = keypad_lamp_o[b];
         repeat (20)
         begin
            @(posedge core_clk_i);
            if (keypad_lamp_o[b] !== p)
               c = c + 1;
            p = keypad_lamp_o[b];
         end
         chk(c >= 2, 1);
      end
   endtask
   // ----------
   // Main sequence
   // ----------
   initial
   begin
      repeat (6) @(posedge core_clk_i);
      reset_n_i <= 1'h1;
      @(posedge core_clk_i);
      wb(0, 8'h04, 32'h0);
      chk(q, 32'h780);
      wb(0, 8'h3C, 32'h0);
      chk(q, 32'h0);
      u_ctl.ctl(1, 0, 1);
      u_ctl.send(1, 8'h20);
      chk(addr_lamp_o, 1);
      u_ctl.send(1, 8'h11);
      chk(rwls_lamp_o, 1);
      chk(analog_var_o, 1);
      wb(1, 8'h00, 32'h1);
      chk(analog_var_o, 0);
      wb(1, 8'h00, 32'h0);
      panel(0, 0);
      panel(1, 1);
      u_ctl.send(1, 8'h08);
      wb(0, 8'h14, 32'h0);
      chk(q[0], 1);
      chk(n_trg, 1);
      wb(1, 8'h14, 32'h3);
      wb(1, 8'h0C, 32'h1AB);
      u_ctl.send(1, 8'h14);
      wb(0, 8'h04, 32'h0);
      chk({q[5:4], q[2]}, 3'h1);
      chk(n_dcl, 1);
      u_ctl.ctl(1, 0, 0);
      repeat (3) @(posedge core_clk_i);
      chk(rwls_lamp_o, 0);
      panel(0, 1);
      u_ctl.send(0, 8'h0A);
      wb(0, 8'h08, 32'h0);
      chk(q[9:0], 10'h20A);
      u_ctl.send(1, 8'h3F);
      chk(addr_lamp_o, 0);
      u_ctl.send(1, 8'h40);
      wb(0, 8'h04, 32'h0);
      chk(q[2:0], 3'h3);
      wb(1, 8'h0C, 32'h1C3);
      u_ctl.ctl(0, 0, 0);
      u_ctl.recv(0, rb, re);
      chk({re, rb}, 9'h1C3);
      wb(1, 8'h10, 32'h45);
      chk(srq_lamp_o, 1);
      u_ctl.send(1, 8'h18);
      u_ctl.send(1, 8'h40);
      u_ctl.ctl(0, 0, 0);
      u_ctl.recv(5, rb, re);
      chk(rb, 8'h45);
      chk(srq_lamp_o, 0);
      u_ctl.send(1, 8'h19);
      // Selected clear only counts while listening; power-on no longer set
      wb(1, 8'h10, 32'h80);
      wb(1, 8'h10, 32'h42);
      chk(srq_oe_o, 1);
      u_ctl.send(1, 8'h04);
      chk(srq_lamp_o, 1);
      u_ctl.send(1, 8'h20);
      u_ctl.send(1, 8'h04);
      chk(srq_lamp_o, 0);
      chk(n_dcl, 2);
      u_ctl.send(1, 8'h3F);
      // Byte is still in its settle delay when interface clear cuts it off
      wb(1, 8'h0C, 32'h7E);
      u_ctl.ctl(0, 0, 0);
      repeat (10) @(posedge core_clk_i);
      u_ctl.ctl(0, 1, 0);
      repeat (3) @(posedge core_clk_i);
      chk(addr_lamp_o, 0);
      u_ctl.ctl(1, 0, 0);
      u_ctl.send(1, 8'h40);
      u_ctl.ctl(0, 0, 0);
      u_ctl.recv(0, rb, re);
      chk({re, rb}, 9'h07E);
      press(4'h1);
      chk(menu_lamp_o, 1);
      press(4'h2);
      chk(keypad_lamp_o[2:0], 3'h3);
      blink(3);
      press(4'h2);
      chk(keypad_lamp_o[2:0], 3'h0);
      press(4'h4);
      chk(keypad_lamp_o[2:0], 3'h4);
      press(4'h4);
      chk(keypad_lamp_o[2], 0);
      press(4'h8);
      chk(keypad_lamp_o[4:0], 5'h00);
      for (i = 0; i < 30; i = i + 1)
         press(4'h8);
      chk(keypad_lamp_o[4:0], 5'h1E);
      press(4'h8);
      chk(keypad_lamp_o[4:0], 5'h00);
      press(4'h8);
      chk(keypad_lamp_o[4:0], 5'h01);
      press(4'h1);
      chk({menu_lamp_o, keypad_lamp_o}, 7'h00);
      wb(0, 8'h04, 32'h0);
      chk(q[15:8], 8'h08);
      chk({dio_oe_o, dav_oe_o, nrfd_oe_o, ndac_oe_o, srq_oe_o}, 0);
      chk(u_ctl.n_to, 0);
      conclude;
   end
endmodule // tb_top
